/* File: rtl/cct_pkg.sv */
package cct_pkg;

    // sample path widths
    localparam int SAMPLE_W = 8;
    localparam int TS_W = 32;
    localparam int CNT_W = 16;
    localparam int RUN_W = 8;
    localparam int PROBE_BITS = 8;

    // internal sample clock derived from the 100 MHz core clock
    localparam int CLK_NS = 10;
    localparam int SAMPLE_NS = 40;
    localparam int SAMPLE_DIV = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIV_W = 3;

    // setup/hold window in samples
    localparam logic [RUN_W-1:0] SH_WIN = 8'h02;

    // event class positions in the enable mask
    localparam int EV_GLITCH = 0;
    localparam int EV_SETHOLD = 1;
    localparam int EV_RUNT = 2;
    localparam int EV_PEER = 3;
    localparam int EV_N = 4;

    // acquisition status, gray coded along the usual path
    typedef enum logic [2:0] {
        CCT_IDLE = 3'h0,
        CCT_ARM = 3'h1,
        CCT_PRE = 3'h3,
        CCT_POST = 3'h2,
        CCT_STOP = 3'h6,
        CCT_READ = 3'h7
    } cct_state_t;

    // action taken when the trigger fires
    typedef enum logic [1:0] {
        CCT_ACT_NONE = 2'h0,
        CCT_ACT_SYS = 2'h1,
        CCT_ACT_ARM = 2'h2,
        CCT_ACT_EVENT = 2'h3
    } cct_action_t;

    // static setup of one module
    typedef struct packed {
        logic module_en;
        logic wait_arm;
        logic repetitive;
        logic qual_en;
        logic [EV_N-1:0] ev_en;
        cct_action_t act;
        logic [SAMPLE_W-1:0] hi;
        logic [SAMPLE_W-1:0] lo;
        logic [CNT_W-1:0] post_len;
    } cct_cfg_t;

    // pins that cross into the core clock
    typedef struct packed {
        logic start;
        logic stop;
        logic arm;
        logic peer_ev;
        logic sys_trig;
        logic ts_clr;
        logic ref_in;
        logic qual;
        logic [SAMPLE_W-1:0] sample;
        logic [PROBE_BITS-1:0] probe;
    } cct_pins_t;

    // one stored sample
    typedef struct packed {
        logic [TS_W-1:0] ts;
        logic [SAMPLE_W-1:0] data;
    } cct_entry_t;

    // one merged result line, src 0 = own memory, 1 = peer
    typedef struct packed {
        logic src;
        cct_entry_t e;
    } cct_out_t;

endpackage

/* File: rtl/cct_ring_mem.sv */
`timescale 1ns/100ps
module cct_ring_mem import cct_pkg::*; #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input cct_entry_t i_wr_data,
    // read port, data one cycle later
    input wire logic i_rd_en,
    input wire logic [AW-1:0] i_rd_addr,
    output cct_entry_t o_rd_data
);

    cct_entry_t mem [DEPTH];

    // storage array, no reset
    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // registered read data
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en) begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule

/* File: rtl/cct_skid2.sv */
`timescale 1ns/100ps
module cct_skid2 import cct_pkg::*; (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // fill side
    input wire logic i_valid,
    input cct_out_t i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output cct_out_t o_data,
    input wire logic i_ready
);

    typedef struct packed {
        cct_out_t e0;
        cct_out_t e1;
        logic v0;
        logic v1;
    } cct_skid_t;

    cct_skid_t c;
    cct_skid_t next_c;

    // pop from head, then push into first free slot
    always_comb begin
        next_c = c;
        if (c.v0 && i_ready) begin
            next_c.e0 = c.e1;
            next_c.v0 = c.v1;
            next_c.v1 = 1'b0;
        end
        if (i_valid && !c.v1) begin
            if (!next_c.v0) begin
                next_c.e0 = i_data;
                next_c.v0 = 1'b1;
            end else begin
                next_c.e1 = i_data;
                next_c.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    // full only when both slots hold data
    assign o_ready = !c.v1;
    assign o_valid = c.v0;
    assign o_data = c.e0;

endmodule

/* File: rtl/cct_capture_ctrl.sv */
`timescale 1ns/100ps
// Function
// - After start, one sample is taken on every internally generated sample strobe.
// - Samples fill memory in ring order and then overwrite the oldest entry.
// - A detected trigger event starts the posttrigger counter so memory keeps filling.
// - Acquisition halts after trigger when the posttrigger count is reached, or at once on a stop command.
// - The detector recognises glitches, setup/hold violations, runts and peer events.
// - On trigger the programmed action runs, such as a system trigger to all modules.
// - A common start begins acquisition unless the module is disabled or waits for arm.
// - The module stops on its own trigger programming, or on a peer event or system trigger when the peer class is enabled.
// - In repetitive mode a new acquisition follows each one until a stop command.
// - The module can raise an arm for a peer and react to peer event signals.
// - Every stored sample carries a time stamp from the shared timebase.
// - The sensed probe attenuation code is sampled and made available.
// - Merged results leave in time stamp order, one sample of one source per entry.
// - With qualification on, only samples meeting the qualifier are stored.
module cct_capture_ctrl import cct_pkg::*; #(
    parameter int DEPTH = 1024,
    parameter int GLITCH_MAX = 2
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // setup and system commands
    input cct_cfg_t i_cfg,
    input wire logic i_start,
    input wire logic i_stop,
    // front end pins
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic i_ref,
    input wire logic i_qual,
    input wire logic [PROBE_BITS-1:0] i_probe_sense,
    // peer module signals
    input wire logic i_arm,
    input wire logic i_peer_event,
    input wire logic i_sys_trigger,
    input wire logic i_ts_clear,
    output logic o_sys_trigger,
    output logic o_arm,
    output logic o_event,
    // peer result stream
    input wire logic i_peer_valid,
    input cct_entry_t i_peer_entry,
    input wire logic i_peer_done,
    output logic o_peer_ready,
    // status and merged results
    output cct_state_t o_status,
    output logic [PROBE_BITS-1:0] o_probe_atten,
    output logic o_out_valid,
    output cct_out_t o_out,
    input wire logic i_out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam int SAMP_WIN = SAMPLE_DIV;

    typedef struct packed {
        cct_pins_t s1;
        cct_pins_t s2;
        logic start_d;
        cct_state_t st;
        logic [DIV_W-1:0] div;
        logic [TS_W-1:0] ts;
        logic [AW-1:0] wptr;
        logic wrapped;
        logic [CNT_W-1:0] plen;
        logic [CNT_W-1:0] pcnt;
        logic rep;
        logic lvl;
        logic above;
        logic ref_d;
        logic runt_arm;
        logic [RUN_W-1:0] run;
        logic [RUN_W-1:0] since_d;
        logic [RUN_W-1:0] since_r;
        logic [AW-1:0] rptr;
        logic [AW:0] left;
        logic pend;
        logic a_v;
        logic b_v;
        logic b_rdy;
        cct_entry_t b;
        logic sys_trig;
        logic arm_out;
        logic ev_out;
        logic [PROBE_BITS-1:0] probe;
    } cct_core_t;

    cct_core_t c;
    cct_core_t next_c;
    cct_pins_t pins;
    cct_entry_t rd_entry;
    logic samp_en, start_p, lvl, above, ref_edge, d_edge;
    logic glitch, runt, shv, peer, hit, store;
    logic rd_en, mem_done, take_a, take_b, buf_valid, buf_ready;
    cct_out_t buf_data;

    // raw pins bundled for the two-stage synchroniser
    assign pins = '{start: i_start, stop: i_stop, arm: i_arm, peer_ev: i_peer_event,
                    sys_trig: i_sys_trigger, ts_clr: i_ts_clear, ref_in: i_ref,
                    qual: i_qual, sample: i_sample, probe: i_probe_sense};

    // next state of the whole core
    always_comb begin
        next_c = c;
        next_c.s1 = pins;
        next_c.s2 = c.s1;
        next_c.start_d = c.s2.start;
        next_c.sys_trig = 1'b0;
        next_c.ev_out = 1'b0;
        start_p = c.s2.start && !c.start_d;
        samp_en = (c.div == DIV_W'(SAMPLE_DIV - 1));
        next_c.div = samp_en ? '0 : c.div + 1'b1;
        next_c.ts = c.s2.ts_clr ? '0 : c.ts + 1'b1;
        next_c.probe = c.s2.probe;

        lvl = (c.s2.sample >= i_cfg.hi);
        above = (c.s2.sample >= i_cfg.lo);
        ref_edge = c.s2.ref_in && !c.ref_d;
        d_edge = (lvl != c.lvl);
        glitch = samp_en && c.lvl && !lvl && (c.run < RUN_W'(GLITCH_MAX));
        runt = samp_en && c.runt_arm && !above;
        shv = samp_en && ((ref_edge && (d_edge || (c.since_d < SH_WIN))) ||
                          (d_edge && (c.since_r < SH_WIN)));
        peer = c.s2.peer_ev || c.s2.sys_trig;
        hit = |(i_cfg.ev_en & {peer, runt, shv, glitch});
        if (samp_en) begin
            next_c.lvl = lvl;
            next_c.above = above;
            next_c.ref_d = c.s2.ref_in;
            if (lvl && !c.lvl) begin
                next_c.run = '0;
            end else if (c.run != '1) begin
                next_c.run = c.run + 1'b1;
            end
            if (lvl || !above) begin
                next_c.runt_arm = 1'b0;
            end else if (!c.above) begin
                next_c.runt_arm = 1'b1;
            end
            next_c.since_d = d_edge ? '0 : (c.since_d == '1 ? c.since_d : c.since_d + 1'b1);
            next_c.since_r = ref_edge ? '0 : (c.since_r == '1 ? c.since_r : c.since_r + 1'b1);
        end

        store = samp_en && (c.st == CCT_PRE || c.st == CCT_POST) &&
                (!i_cfg.qual_en || c.s2.qual);
        if (store) begin
            if (c.wptr == AW'(DEPTH - 1)) begin
                next_c.wptr = '0;
                next_c.wrapped = 1'b1;
            end else begin
                next_c.wptr = c.wptr + 1'b1;
            end
        end

        // merge of own memory and peer stream
        mem_done = (c.left == '0) && !c.pend && !c.a_v;
        take_a = c.a_v && ((i_peer_done && !c.b_v) || (c.b_v && (rd_entry.ts <= c.b.ts)));
        take_b = c.b_v && !take_a && (c.a_v || mem_done);
        rd_en = 1'b0;
        buf_valid = 1'b0;
        buf_data = take_a ? {1'b0, rd_entry} : {1'b1, c.b};

        case (c.st)
            CCT_IDLE: begin
                if (start_p && i_cfg.module_en) begin
                    next_c.plen = i_cfg.post_len;
                    next_c.rep = i_cfg.repetitive;
                    next_c.wptr = '0;
                    next_c.wrapped = 1'b0;
                    next_c.arm_out = 1'b0;
                    next_c.st = i_cfg.wait_arm ? CCT_ARM : CCT_PRE;
                end
            end
            CCT_ARM: begin
                if (c.s2.arm) begin
                    next_c.st = CCT_PRE;
                end
            end
            CCT_PRE: begin
                if (samp_en && hit) begin
                    next_c.pcnt = '0;
                    next_c.st = (c.plen == '0) ? CCT_STOP : CCT_POST;
                    case (i_cfg.act)
                        CCT_ACT_SYS: next_c.sys_trig = 1'b1;
                        CCT_ACT_ARM: next_c.arm_out = 1'b1;
                        CCT_ACT_EVENT: next_c.ev_out = 1'b1;
                        default: next_c.sys_trig = 1'b0;
                    endcase
                end
            end
            CCT_POST: begin
                if (store) begin
                    next_c.pcnt = c.pcnt + 1'b1;
                    if (c.pcnt + 1'b1 == c.plen) begin
                        next_c.st = CCT_STOP;
                    end
                end
            end
            CCT_STOP: begin
                // readout starts at the oldest sample
                next_c.rptr = c.wrapped ? c.wptr : '0;
                next_c.left = c.wrapped ? (AW + 1)'(DEPTH) : {1'b0, c.wptr};
                next_c.pend = 1'b0;
                next_c.a_v = 1'b0;
                next_c.b_v = 1'b0;
                next_c.st = CCT_READ;
            end
            CCT_READ: begin
                buf_valid = take_a || take_b;
                if (take_a && buf_ready) begin
                    next_c.a_v = 1'b0;
                end
                if (take_b && buf_ready) begin
                    next_c.b_v = 1'b0;
                end
                if (c.b_rdy && i_peer_valid) begin
                    next_c.b_v = 1'b1;
                    next_c.b = i_peer_entry;
                end
                rd_en = !c.pend && !c.a_v && (c.left != '0);
                next_c.pend = rd_en;
                if (c.pend) begin
                    next_c.a_v = 1'b1;
                end
                if (rd_en) begin
                    next_c.rptr = (c.rptr == AW'(DEPTH - 1)) ? '0 : c.rptr + 1'b1;
                    next_c.left = c.left - 1'b1;
                end
                if (mem_done && i_peer_done && !c.b_v) begin
                    next_c.st = CCT_IDLE;
                    if (c.rep) begin
                        next_c.wptr = '0;
                        next_c.wrapped = 1'b0;
                        next_c.arm_out = 1'b0;
                        next_c.st = i_cfg.wait_arm ? CCT_ARM : CCT_PRE;
                    end
                end
            end
            default: next_c.st = CCT_IDLE;
        endcase

        if (c.s2.stop) begin
            next_c.st = CCT_IDLE;
            next_c.rep = 1'b0;
        end
        next_c.b_rdy = (next_c.st == CCT_READ) && !next_c.b_v;
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    // sample stored with its time stamp
    cct_ring_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_wr_en(store),
        .i_wr_addr(c.wptr),
        .i_wr_data({c.ts, c.s2.sample}),
        .i_rd_en(rd_en),
        .i_rd_addr(c.rptr),
        .o_rd_data(rd_entry)
    );

    // two-entry buffer absorbs receiver stalls
    cct_skid2 u_buf (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_valid(buf_valid),
        .i_data(buf_data),
        .o_ready(buf_ready),
        .o_valid(o_out_valid),
        .o_data(o_out),
        .i_ready(i_out_ready)
    );

    assign o_status = c.st;
    assign o_sys_trigger = c.sys_trig;
    assign o_arm = c.arm_out;
    assign o_event = c.ev_out;
    assign o_peer_ready = c.b_rdy;
    assign o_probe_atten = c.probe;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    strobe_rate_a: assert property (
        (c.st == CCT_PRE) |-> ##[1:SAMP_WIN] samp_en)
        else $error("sample strobe missing");
    ring_advance_a: assert property (
        store && c.wptr != AW'(DEPTH - 1) |=> c.wptr == $past(c.wptr) + 1'b1)
        else $error("write pointer did not advance");
    trig_post_a: assert property (
        c.st == CCT_PRE && samp_en && hit && !c.s2.stop && c.plen != '0 |=> c.st == CCT_POST)
        else $error("trigger did not start posttrigger");
    post_stop_a: assert property (
        (c.st == CCT_POST) ##1 (c.st == CCT_STOP) |-> c.pcnt == c.plen)
        else $error("stopped before posttrigger count");
    sys_action_a: assert property (
        (c.st == CCT_PRE) ##1 (c.st == CCT_POST && i_cfg.act == CCT_ACT_SYS) |-> o_sys_trigger)
        else $error("system trigger not raised");
    start_go_a: assert property (
        c.st == CCT_IDLE && start_p && i_cfg.module_en && !i_cfg.wait_arm && !c.s2.stop
        |=> c.st == CCT_PRE)
        else $error("common start ignored");
    disabled_hold_a: assert property (
        c.st == CCT_IDLE && !i_cfg.module_en |=> c.st == CCT_IDLE)
        else $error("disabled module started");
    qual_drop_a: assert property (
        i_cfg.qual_en && !c.s2.qual && c.st inside {CCT_PRE, CCT_POST} |=> $stable(c.wptr))
        else $error("unqualified sample stored");
    merge_order_a: assert property (
        c.st == CCT_READ && take_a && c.b_v |-> rd_entry.ts <= c.b.ts)
        else $error("merge out of time order");
    post_len_a: assert property (
        c.st == CCT_POST |=> $stable(c.plen))
        else $error("posttrigger length changed");

endmodule

/* File: verification/cct_peer_model.sv */
`timescale 1ns/100ps
module cct_peer_model import cct_pkg::*; (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // pacing, high adds idle cycles between entries
    input wire logic i_slow,
    // result stream toward the capture block
    output logic o_valid,
    output cct_entry_t o_entry,
    output logic o_done,
    input wire logic i_ready
);
    cct_entry_t pend[$];
    cct_entry_t last = '0;
    int gap = 0;

    // bench queues entries in time stamp order
    task automatic push(input cct_entry_t e);
        pend.push_back(e);
    endtask

    // offer stays put until taken, then the next one after any gap
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_valid <= 1'b0;
            o_entry <= '1;
            o_done <= 1'b1;
            gap = 0;
        end else if (!(o_valid && !i_ready)) begin
            if (o_valid) begin
                last = pend.pop_front();
                gap = i_slow ? 3 : 0;
            end
            if (gap == 0 && pend.size() > 0) begin
                o_valid <= 1'b1;
                o_entry <= pend[0];
            end else begin
                o_valid <= 1'b0;
                // released lines show the inverse of the last value
                o_entry <= cct_entry_t'(~last);
                if (gap > 0) begin
                    gap--;
                end
            end
            o_done <= (pend.size() == 0);
        end
    end
endmodule

/* File: verification/circular_capture_trigger_control_bench.sv */
`timescale 1ns/100ps
module circular_capture_trigger_control_bench import cct_pkg::*; ();
    // clock, reset and stimulus
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    cct_cfg_t cfg = '0;
    logic i_start = 1'b0;
    logic i_stop = 1'b0;
    logic [SAMPLE_W-1:0] i_sample = 8'h00;
    logic i_ref = 1'b0;
    logic i_qual = 1'b1;
    logic [PROBE_BITS-1:0] i_probe = 8'h00;
    logic i_arm = 1'b0;
    logic i_peer_event = 1'b0;
    logic i_sys_trigger = 1'b0;
    logic i_ts_clear = 1'b1;
    logic i_out_ready = 1'b1;
    logic slow = 1'b0;
    // design outputs and peer stream
    logic o_sys_trigger, o_arm, o_event, o_peer_ready, o_out_valid, peer_valid, peer_done;
    cct_entry_t peer_entry;
    cct_state_t o_status;
    logic [PROBE_BITS-1:0] o_probe_atten;
    cct_out_t o_out;
    // scoreboard
    int bad_count = 0;
    int checks = 0;
    logic seen_sys = 1'b0;
    logic seen_ev = 1'b0;

    cct_capture_ctrl #(.DEPTH(8), .GLITCH_MAX(2)) u_dut (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_cfg(cfg), .i_start(i_start),
        .i_stop(i_stop), .i_sample(i_sample), .i_ref(i_ref), .i_qual(i_qual),
        .i_probe_sense(i_probe), .i_arm(i_arm), .i_peer_event(i_peer_event),
        .i_sys_trigger(i_sys_trigger), .i_ts_clear(i_ts_clear),
        .o_sys_trigger(o_sys_trigger), .o_arm(o_arm), .o_event(o_event),
        .i_peer_valid(peer_valid), .i_peer_entry(peer_entry), .i_peer_done(peer_done),
        .o_peer_ready(o_peer_ready), .o_status(o_status), .o_probe_atten(o_probe_atten),
        .o_out_valid(o_out_valid), .o_out(o_out), .i_out_ready(i_out_ready));

    cct_peer_model u_peer (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_slow(slow), .o_valid(peer_valid),
        .o_entry(peer_entry), .o_done(peer_done), .i_ready(o_peer_ready));

    // 100 MHz clock
    always #5 i_clock = ~i_clock;

    // compare helpers
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_state(input string what, input cct_state_t exp, input cct_state_t got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // advance at falling edges, noting action pulses
    task automatic step(input int n);
        repeat (n) begin
            @(negedge i_clock);
            seen_sys = seen_sys | (o_sys_trigger === 1'b1);
            seen_ev = seen_ev | (o_event === 1'b1);
        end
    endtask
    task automatic wait_status(input cct_state_t exp, input int bound);
        int n;
        n = 0;
        while (o_status !== exp && n < bound) begin
            step(1);
            n++;
        end
        if (o_status !== exp) begin
            chk_state("status wait", exp, o_status);
            end_of_test();
        end
    endtask

    // setup used by most runs: peer class, short post count
    task automatic base(input int cls, input cct_action_t act);
        cfg = '0;
        cfg.module_en = 1'b1;
        cfg.ev_en = 4'(1 << cls);
        cfg.act = act;
        cfg.hi = 8'h50;
        cfg.lo = 8'h28;
        cfg.post_len = 16'h0003;
    endtask
    task automatic start_run(input cct_state_t first);
        u_peer.push({32'h00000000, 8'hA1});
        u_peer.push({32'hFFFFFFF0, 8'hA2});
        seen_sys = 1'b0;
        seen_ev = 1'b0;
        i_start = 1'b1;
        wait_status(first, 10);
        i_start = 1'b0;
        if (first == CCT_PRE) begin
            chk_bit("arm cleared at start", 1'b0, o_arm);
        end
    endtask
    task automatic fire(input int cls);
        case (cls)
            EV_GLITCH: begin
                i_sample = 8'hFF;
                step(4);
                i_sample = 8'h00;
            end
            EV_SETHOLD: begin
                i_sample = 8'hFF;
                step(2);
                i_ref = 1'b1;
                step(4);
                i_ref = 1'b0;
            end
            EV_RUNT: begin
                i_sample = 8'h3C;
                step(8);
                i_sample = 8'h00;
            end
            default: begin
                i_peer_event = 1'b1;
                step(8);
                i_peer_event = 1'b0;
            end
        endcase
    endtask

    // readout with a stalling receiver; counts and orders the lines
    task automatic drain(input int exp_own, input cct_state_t end_st);
        logic [TS_W-1:0] last_ts;
        logic [TS_W-1:0] last_own;
        cct_out_t held;
        logic held_v;
        int n;
        int own;
        int peer;
        n = 0;
        own = 0;
        peer = 0;
        last_ts = '0;
        last_own = '0;
        held_v = 1'b0;
        held = '0;
        while (!(o_status === end_st && o_out_valid === 1'b0) && n < 600) begin
            step(1);
            n++;
            if (held_v) begin
                chk_val("stalled line", 64'(held), 64'(o_out));
            end
            i_out_ready = (n % 3 != 0);
            held_v = o_out_valid && !i_out_ready;
            held = o_out;
            if (o_out_valid === 1'b1 && i_out_ready) begin
                chk_bit("time order", 1'b1, o_out.e.ts >= last_ts);
                last_ts = o_out.e.ts;
                if (o_out.src === 1'b0) begin
                    if (own > 0) begin
                        chk_val("stamp step", SAMPLE_DIV, o_out.e.ts - last_own);
                    end
                    last_own = o_out.e.ts;
                    own++;
                end else begin
                    peer++;
                end
            end
        end
        i_out_ready = 1'b1;
        if (!(o_status === end_st && o_out_valid === 1'b0)) begin
            chk_bit("readout finished", 1'b1, 1'b0);
            end_of_test();
        end
        chk_state("after readout", end_st, o_status);
        chk_val("own lines", exp_own, own);
        chk_val("peer lines", 2, peer);
    endtask
    task automatic finish_run(input cct_action_t act, input int exp_own, input cct_state_t st);
        wait_status(CCT_POST, 24);
        chk_bit("system trigger pulse", act == CCT_ACT_SYS, seen_sys);
        chk_bit("event pulse", act == CCT_ACT_EVENT, seen_ev);
        chk_bit("arm level", act == CCT_ACT_ARM, o_arm);
        step(6);
        chk_state("still filling", CCT_POST, o_status);
        wait_status(CCT_READ, 80);
        drain(exp_own, st);
    endtask

    // scenarios
    task automatic sc_reset();
        chk_state("status in reset", CCT_IDLE, o_status);
        chk_bit("valid in reset", 1'b0, o_out_valid);
        chk_bit("arm in reset", 1'b0, o_arm);
        chk_bit("peer ready in reset", 1'b0, o_peer_ready);
    endtask
    task automatic sc_probe();
        i_probe = 8'h5A;
        step(6);
        chk_val("probe code", 8'h5A, o_probe_atten);
    endtask
    task automatic sc_disabled();
        base(EV_PEER, CCT_ACT_NONE);
        cfg.module_en = 1'b0;
        i_start = 1'b1;
        step(20);
        chk_state("disabled start", CCT_IDLE, o_status);
        i_start = 1'b0;
        step(4);
    endtask
    task automatic sc_classes();
        for (int c = 0; c < EV_N; c++) begin
            base(c, cct_action_t'(c));
            start_run(CCT_PRE);
            step(60);
            chk_state("no false trigger", CCT_PRE, o_status);
            fire(c);
            finish_run(cct_action_t'(c), 8, CCT_IDLE);
            i_sample = 8'h00;
            step(4);
        end
    endtask
    task automatic sc_wait_arm();
        base(EV_PEER, CCT_ACT_SYS);
        cfg.wait_arm = 1'b1;
        slow = 1'b1;
        start_run(CCT_ARM);
        step(30);
        chk_state("waiting for arm", CCT_ARM, o_status);
        i_arm = 1'b1;
        wait_status(CCT_PRE, 10);
        i_arm = 1'b0;
        step(60);
        i_sys_trigger = 1'b1;
        step(8);
        i_sys_trigger = 1'b0;
        finish_run(CCT_ACT_SYS, 8, CCT_IDLE);
        slow = 1'b0;
    endtask
    task automatic sc_qualifier();
        base(EV_PEER, CCT_ACT_NONE);
        cfg.qual_en = 1'b1;
        i_qual = 1'b0;
        start_run(CCT_PRE);
        step(60);
        fire(EV_PEER);
        wait_status(CCT_POST, 24);
        step(100);
        chk_state("post without stores", CCT_POST, o_status);
        i_qual = 1'b1;
        wait_status(CCT_READ, 80);
        drain(3, CCT_IDLE);
    endtask
    task automatic sc_repeat();
        base(EV_PEER, CCT_ACT_NONE);
        cfg.repetitive = 1'b1;
        start_run(CCT_PRE);
        step(60);
        fire(EV_PEER);
        finish_run(CCT_ACT_NONE, 8, CCT_PRE);
        step(20);
        chk_state("restarted run", CCT_PRE, o_status);
        i_stop = 1'b1;
        wait_status(CCT_IDLE, 10);
        step(20);
        chk_state("stopped", CCT_IDLE, o_status);
        i_stop = 1'b0;
        cfg.repetitive = 1'b0;
    endtask

    // main sequence
    initial begin
        repeat (12) @(negedge i_clock);
        sc_reset();
        i_reset_n = 1'b1;
        step(3);
        i_ts_clear = 1'b0;
        sc_probe();
        sc_disabled();
        sc_classes();
        sc_wait_arm();
        sc_qualifier();
        sc_repeat();
        end_of_test();
    end
endmodule
